// ===== wd_pkg.sv
package wd_pkg;
  // ****************************************
  // counter values and bit positions
  // ****************************************
  localparam logic [2:0] FAIL_INIT = 3'h5;
  localparam logic [2:0] FAIL_MAX = 3'h7;
  localparam logic [2:0] FAIL_LIMIT = 3'h4;
  localparam int QA_MODE_BIT = 5;
  localparam int RST_EN_BIT = 3;
  localparam int TIMEOUT_BIT = 1;
  localparam int EARLY_BIT = 0;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int PULSE_NS = 32000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_NS = 550000;
  localparam int STEP_CYC = (STEP_NS * CLK_MHZ) / 1000;
  localparam logic [6:0] WIN1_RESET = 7'h10;
  localparam logic [4:0] WIN2_RESET = 5'h10;
  // ****************************************
  // device and window states, events
  // ****************************************
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_DIAG = 2'b01,
    ST_ACTIVE = 2'b10
  } dev_state_e;
  typedef enum logic [1:0] {
    WIN_CLOSED = 2'b00,
    WIN_OPEN = 2'b01
  } win_state_e;
  typedef struct packed {
    logic good;
    logic bad;
    logic timeout;
  } wd_event_s;
endpackage

// ===== watchdog_fail_counter.sv
`timescale 1ns/1ps
// How it works
// - enable output follows request when healthy
// - two modes; trigger mode after reset
// - qa select taken only in diagnostic
// - three-bit fail counter up and down
// - count five or more forces enable low
// - count four or less allows request
// - counter ignores reset-enable bit
// - good event decrements, floor zero
// - bad event increments, ceiling seven
// - timeout increments and sets timeout flag
// - load five entering diagnostic and active
// - at seven with enable, next fault resets
// - reset state reloads count to five
// - enable set at seven resets at once
// - closed-window trigger is bad, early flag
// - open-window trigger is good, restart
// - no trigger in sequence gives timeout
// - frame active blocks flag, not count
module watchdog_fail_counter import wd_pkg::*; #(
  parameter int STEP_CYCLES = STEP_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic error_trigger_input,
  input wire logic spi_cs_n,
  input wire logic [7:0] safety_function_config,
  input wire logic drive_enable_request,
  input wire logic other_drive_error,
  input wire logic qa_good,
  input wire logic qa_bad,
  input wire logic go_active,
  input wire logic status_clear,
  input wire logic [6:0] win1_steps,
  input wire logic [4:0] win2_steps,
  input wire logic reset_done,
  output logic drive_enable_out,
  output logic mcu_reset_out,
  output logic qa_mode,
  output logic [2:0] fail_count,
  output logic in_range,
  output logic [1:0] watchdog_status_reg,
  output logic [1:0] device_state
);
  // the step counter is 20 bits wide, so longer steps cannot be served
  if (STEP_CYCLES < 2 || STEP_CYCLES > 1000000) begin : g_step_check
    $error("bad STEP_CYCLES");
  end

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [1:0] trig_sync_q, cs_sync_q;
  logic trig_prev_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trig_sync_q <= 2'h0;
      cs_sync_q <= 2'h3;
      trig_prev_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[0], error_trigger_input};
      cs_sync_q <= {cs_sync_q[0], spi_cs_n};
      trig_prev_q <= trig_sync_q[1];
    end
  end

  // ****************************************
  // trigger deglitch: high longer than pulse time then falling edge
  // ****************************************
  logic [15:0] hi_cnt_q;
  wire trig_hi = trig_sync_q[1];
  wire trig_fall = trig_prev_q && !trig_hi;
  wire long_enough = hi_cnt_q >= 16'(PULSE_CYC);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi_cnt_q <= 16'h0;
    end else if (!trig_hi) begin
      hi_cnt_q <= 16'h0;
    end else if (!long_enough) begin
      hi_cnt_q <= hi_cnt_q + 16'h1;
    end
  end

  // ****************************************
  // device state and mode
  // ****************************************
  dev_state_e state_q, state_d;
  logic qa_q;
  logic [2:0] cnt_q, cnt_d;
  wire rst_en = safety_function_config[RST_EN_BIT];
  wire cnt_at_max = cnt_q == FAIL_MAX;
  logic trig_event;
  wd_event_s ev;
  logic rst_en_q;
  wire fault = ev.bad || ev.timeout;
  // enable already set when the count reaches seven waits for the next fault,
  // while enable newly set at seven resets without one
  wire go_reset = rst_en && cnt_at_max && (fault || !rst_en_q);
  // mode output takes the same next value as qa_q, so it trails a state change by one cycle
  wire qa_d = (state_q == ST_RESET) ? 1'b0 :
    (state_q == ST_DIAG) ? safety_function_config[QA_MODE_BIT] : qa_q;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RESET: begin
        if (reset_done) begin
          state_d = ST_DIAG;
        end
      end
      ST_DIAG: begin
        if (go_reset) begin
          state_d = ST_RESET;
        end else if (go_active) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (go_reset) begin
          state_d = ST_RESET;
        end
      end
      default: state_d = ST_RESET;
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_RESET;
      qa_q <= 1'b0;
      rst_en_q <= 1'b0;
    end else begin
      state_q <= state_d;
      qa_q <= qa_d;
      rst_en_q <= rst_en;
    end
  end

  // ****************************************
  // window sequencer (trigger mode)
  // ****************************************
  win_state_e win_q;
  logic [19:0] step_q;
  logic [6:0] steps_q;
  wire step_tick = step_q == 20'(STEP_CYCLES - 1);
  wire run = state_q != ST_RESET;
  wire trig_mode = !qa_q;
  wire win1_end = win_q == WIN_CLOSED && step_tick && steps_q >= win1_steps;
  wire win2_end = win_q == WIN_OPEN && step_tick && steps_q >= 7'(win2_steps) + 7'h1;
  assign trig_event = run && trig_mode && trig_fall && long_enough;
  wire early = trig_event && win_q == WIN_CLOSED;
  wire restart = trig_event || win2_end;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      win_q <= WIN_CLOSED;
      step_q <= 20'h0;
      steps_q <= 7'h0;
    end else if (!run || restart || win1_end) begin
      win_q <= (run && win1_end && !trig_event) ? WIN_OPEN : WIN_CLOSED;
      step_q <= 20'h0;
      steps_q <= 7'h0;
    end else begin
      step_q <= step_tick ? 20'h0 : step_q + 20'h1;
      if (step_tick) begin
        steps_q <= steps_q + 7'h1;
      end
    end
  end

  // ****************************************
  // events and fail counter
  // ****************************************
  assign ev.good = (trig_event && !early) || (run && qa_q && qa_good);
  assign ev.bad = early || (run && qa_q && qa_bad);
  assign ev.timeout = run && trig_mode && win2_end && !trig_event;
  wire entering_diag = state_q == ST_RESET && state_d == ST_DIAG;
  wire entering_active = state_q == ST_DIAG && state_d == ST_ACTIVE;
  always_comb begin
    cnt_d = cnt_q;
    if (state_q == ST_RESET || entering_diag || entering_active) begin
      cnt_d = FAIL_INIT;
    end else if (fault && !cnt_at_max) begin
      cnt_d = cnt_q + 3'h1;
    end else if (!fault && ev.good && cnt_q != 3'h0) begin
      cnt_d = cnt_q - 3'h1;
    end
  end
  logic early_q, tout_q;
  wire cs_low = !cs_sync_q[1];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= FAIL_INIT;
      tout_q <= 1'b0;
      early_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (ev.timeout && !cs_low) begin
        tout_q <= 1'b1;
      end else if (status_clear) begin
        tout_q <= 1'b0;
      end
      if (early) begin
        early_q <= 1'b1;
      end else if (status_clear) begin
        early_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // outputs, all registered
  // ****************************************
  wire ok_range = cnt_d <= FAIL_LIMIT;
  wire in_reset_d = state_d == ST_RESET;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drive_enable_out <= 1'b0;
      mcu_reset_out <= 1'b0;
      in_range <= 1'b0;
      fail_count <= FAIL_INIT;
      qa_mode <= 1'b0;
      watchdog_status_reg <= 2'h0;
      device_state <= 2'h0;
    end else begin
      drive_enable_out <= ok_range && drive_enable_request && !other_drive_error
        && !in_reset_d;
      mcu_reset_out <= !in_reset_d;
      in_range <= ok_range;
      fail_count <= cnt_d;
      qa_mode <= qa_d;
      watchdog_status_reg <= {tout_q, early_q};
      device_state <= state_d;
    end
  end
endmodule

// ===== wd_monitor.sv
`timescale 1ns/1ps
module wd_monitor import wd_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] safety_function_config,
  input wire logic reset_done,
  input wire logic drive_enable_out,
  input wire logic mcu_reset_out,
  input wire logic qa_mode,
  input wire logic [2:0] fail_count,
  input wire logic in_range,
  input wire logic [1:0] device_state
);
  // ****
  // checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  out_range_low_a: assert property (fail_count > FAIL_LIMIT &&
    $past(fail_count) > FAIL_LIMIT |-> !drive_enable_out) else $error("enable out of range");
  in_range_a: assert property ($stable(fail_count) |->
    in_range == (fail_count <= FAIL_LIMIT)) else $error("range flag wrong");
  count_step_a: assert property ($changed(fail_count) |-> fail_count == FAIL_INIT ||
    fail_count == $past(fail_count) + 3'h1 || fail_count == $past(fail_count) - 3'h1)
    else $error("count jump");
  reset_now_a: assert property ($rose(safety_function_config[RST_EN_BIT]) &&
    fail_count == FAIL_MAX && device_state != ST_RESET |-> ##[1:3] device_state == ST_RESET)
    else $error("no reset");
  reset_pin_a: assert property (device_state == ST_RESET |-> ##[0:1] !mcu_reset_out)
    else $error("reset pin high");
  reset_load_a: assert property ($changed(device_state) && device_state == ST_RESET
    |-> ##[0:1] fail_count == FAIL_INIT) else $error("no reload");
  diag_entry_a: assert property (device_state == ST_RESET && reset_done |=>
    device_state == ST_DIAG && fail_count == FAIL_INIT && !qa_mode) else $error("bad entry");
  mode_lock_a: assert property (device_state == ST_ACTIVE &&
    $past(device_state) == ST_ACTIVE |-> $stable(qa_mode)) else $error("mode moved");
endmodule

// ===== mcu_model.sv
`timescale 1ns/1ps
module mcu_model (
  input wire logic clk,
  output logic error_trigger_input,
  output logic spi_cs_n,
  output logic qa_good,
  output logic qa_bad
);
  // ****
  // host side; error monitor never used here
  // ****
  initial begin
    error_trigger_input = 1'b0;
    spi_cs_n = 1'b1;
    {qa_good, qa_bad} = 2'b00;
  end
  // held past the pulse filter so the fall counts
  task automatic trigger();
    @(posedge clk) #1 error_trigger_input = 1'b1;
    repeat (3300) @(posedge clk);
    #1 error_trigger_input = 1'b0;
  endtask
  // serial answer reduced to its verdict
  task automatic answer(input logic ok);
    @(posedge clk) #1 {qa_good, qa_bad} = {ok, !ok};
    @(posedge clk) #1 {qa_good, qa_bad} = 2'b00;
  endtask
  task automatic frame(input logic on);
    @(posedge clk) #1 spi_cs_n = !on;
  endtask
endmodule

// ===== testbench.sv
`timescale 1ns/1ps
module testbench import wd_pkg::*; ;
  logic clk, resetn, req, oerr, go, clr, rdone;
  logic trig, cs_n, good, bad, de, nrst, qam, inr;
  logic [7:0] cfg;
  logic [6:0] w1;
  logic [4:0] w2;
  logic [2:0] cnt;
  logic [1:0] st, wsr;
  int n_errors = 0, total_checks = 0, cyc = 0;
  mcu_model u_mcu (.clk(clk), .error_trigger_input(trig), .spi_cs_n(cs_n),
    .qa_good(good), .qa_bad(bad));
  watchdog_fail_counter #(.STEP_CYCLES(100)) uut (.clk(clk), .resetn(resetn),
    .error_trigger_input(trig), .spi_cs_n(cs_n), .safety_function_config(cfg),
    .drive_enable_request(req), .other_drive_error(oerr), .qa_good(good), .qa_bad(bad),
    .go_active(go), .status_clear(clr), .win1_steps(w1), .win2_steps(w2),
    .reset_done(rdone), .drive_enable_out(de), .mcu_reset_out(nrst), .qa_mode(qam),
    .fail_count(cnt), .in_range(inr), .watchdog_status_reg(wsr), .device_state(st));
  // ****
  // helpers
  // ****
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      results();
    end
  end
  task automatic check(input string what, input logic [2:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded: a stuck counter must not hang the run
  task automatic wait_cnt(input logic [2:0] old);
    for (int i = 0; i < 20000 && cnt === old; i++) tick(1);
    tick(1);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_trig();
    tick(9800);
    u_mcu.trigger();
    wait_cnt(3'h5);
    check("count", 3'h4, cnt);
    check("in range", 3'h1, 3'(inr));
    check("enable", 3'h1, 3'(de));
    oerr = 1;
    tick(2);
    check("enable", 3'h0, 3'(de));
    oerr = 0;
    u_mcu.trigger();
    wait_cnt(3'h4);
    check("count", 3'h5, cnt);
    check("status", 3'h1, 3'(wsr));
    check("enable", 3'h0, 3'(de));
    clr = 1;
    tick(1);
    clr = 0;
    tick(1);
    check("status", 3'h0, 3'(wsr));
    $display("trigger done");
  endtask
  task automatic t_qa();
    cfg[QA_MODE_BIT] = 1;
    tick(2);
    check("mode", 3'h1, 3'(qam));
    repeat (8) u_mcu.answer(1);
    tick(1);
    check("count", 3'h0, cnt);
    check("in range", 3'h1, 3'(inr));
    check("enable", 3'h1, 3'(de));
    req = 0;
    tick(1);
    check("enable", 3'h0, 3'(de));
    req = 1;
    repeat (8) u_mcu.answer(0);
    tick(1);
    check("count", 3'h7, cnt);
    check("in range", 3'h0, 3'(inr));
    go = 1;
    tick(1);
    go = 0;
    cfg[QA_MODE_BIT] = 0;
    tick(2);
    check("state", 3'h2, 3'(st));
    check("count", 3'h5, cnt);
    check("mode", 3'h1, 3'(qam));
    $display("qa done");
  endtask
  task automatic t_tmo();
    u_mcu.frame(1);
    wait_cnt(3'h5);
    check("count", 3'h6, cnt);
    check("status", 3'h0, 3'(wsr));
    u_mcu.frame(0);
    wait_cnt(3'h6);
    check("count", 3'h7, cnt);
    check("status", 3'h2, 3'(wsr));
    check("in range", 3'h0, 3'(inr));
    $display("timeout done");
  endtask
  // enable set first, then seven is reached: the following fault resets; then seven first, enable set after: reset without a fault
  task automatic t_rst();
    cfg[RST_EN_BIT] = 1;
    repeat (2) u_mcu.answer(0);
    tick(2);
    check("state", 3'h2, 3'(st));
    check("count", 3'h7, cnt);
    u_mcu.answer(0);
    tick(1);
    check("state", 3'h0, 3'(st));
    check("reset pin", 3'h0, 3'(nrst));
    check("count", 3'h5, cnt);
    cfg = 8'h00;
    rdone = 1;
    tick(1);
    rdone = 0;
    check("state", 3'h1, 3'(st));
    check("count", 3'h5, cnt);
    check("mode", 3'h0, 3'(qam));
    cfg[QA_MODE_BIT] = 1;
    repeat (2) u_mcu.answer(0);
    cfg[RST_EN_BIT] = 1;
    tick(1);
    check("state", 3'h0, 3'(st));
    check("reset pin", 3'h0, 3'(nrst));
    $display("reset done");
  endtask
  initial begin
    {resetn, oerr, go, clr, rdone} = 5'h00;
    req = 1'b1;
    cfg = 8'h00;
    // long closed window so the first trigger lands in the open one
    w1 = 7'h7f;
    w2 = 5'h1f;
    tick(5);
    resetn = 1;
    tick(1);
    rdone = 1;
    tick(1);
    check("state", 3'h1, 3'(st));
    check("enable", 3'h0, 3'(de));
    rdone = 0;
    t_trig();
    t_tmo();
    t_qa();
    t_rst();
    results();
  end
endmodule
bind watchdog_fail_counter wd_monitor u_mon (.clk(clk), .resetn(resetn),
  .safety_function_config(safety_function_config), .reset_done(reset_done),
  .drive_enable_out(drive_enable_out), .mcu_reset_out(mcu_reset_out), .qa_mode(qa_mode),
  .fail_count(fail_count), .in_range(in_range), .device_state(device_state));
